// ==== hw/tsc_trigger_seq.sv ====
// Trigger sequence controller with APB register access
// Contract
// - Abort returns channel to idle
// - Abort keeps all other trigger settings
// - Continuous mode re-arms after one idle cycle following abort
// - Initiation does not block later commands
// - Pending flag follows idle transitions
// - Trigger cycle: leave wait, start measurement
// - Single mode returns idle after one cycle
// - Continuous mode chains cycles without idle
// - Command reset clears continuous; preset sets it
// - Continuous query reads one or zero
// - Single initiation arms, measures, stores result
// - Immediate source measures at once
// - Initiation when busy or continuous: error -213
// - Fetch moves stored result to output
// - All-sequences continuous setting; reset clears
// - Initiate-all initiates every sequence
// - Auto delay inserts settling before measurement
// - No auto delay: measure immediately
// - Forced trigger skips settling delay
// - Forced trigger fires while waiting, stores
// - Forced trigger elsewhere: error -211
// - Selectable bus, ext, hold, imm, int sources
// - Source defaults to immediate
`timescale 1ns/1ns
module tsc_trigger_seq
  import tsc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger inputs
  input wire logic extTrig,
  input wire logic busTrig,
  input wire logic intLevelTrig,
  // Measurement front end
  input wire logic [DATA_W-1:0] measData,
  // Status and output buffer
  output logic [DATA_W-1:0] outBuf,
  output logic outBufValid,
  output logic pendingOp,
  output logic waitingTrig,
  output logic measuring
);

  // Refuse widths that the 32-bit read path cannot carry
  if (DATA_W < 1 || DATA_W > 32) begin : g_badWidth
    $error("DATA_W must be 1..32");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SETTLE, ST_MEAS} tsc_state_t;

  localparam logic [15:0] SETTLE_LAST = 16'(TSC_SETTLE_CYC - 1);
  localparam logic [15:0] MEAS_LAST = 16'(TSC_MEAS_CYC - 1);

  tsc_state_t state_r;
  tsc_state_t state_nxt;
  logic contInit_r;
  logic allCont_r;
  logic autoDelay_r;
  tsc_src_t source_r;
  logic [15:0] count_r;
  logic [DATA_W-1:0] result_r;
  logic resultValid_r;
  logic [31:0] errCode_r;
  logic pending_r;

  logic extSync;
  logic busSync;
  logic intSync;

  // External trigger lines come from other domains
  tsc_sync2 u_syncExt (.clock(clock), .sys_rst(sys_rst), .din(extTrig), .dout(extSync));
  tsc_sync2 u_syncBus (.clock(clock), .sys_rst(sys_rst), .din(busTrig), .dout(busSync));
  tsc_sync2 u_syncInt (.clock(clock), .sys_rst(sys_rst), .din(intLevelTrig), .dout(intSync));

  // Bus decode
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : isReg

  logic wrAccess;
  logic rdAccess;
  logic mapped;
  assign pready = 1'b1;
  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && penable && !pwrite;
  assign mapped = isReg(paddr, TSC_CTRL_OFS) || isReg(paddr, TSC_CMD_OFS) ||
    isReg(paddr, TSC_STAT_OFS) || isReg(paddr, TSC_RESULT_OFS) || isReg(paddr, TSC_ERR_OFS);
  assign pslverr = psel && penable && !mapped;

  logic ctrlWr;
  logic cmdWr;
  assign ctrlWr = wrAccess && isReg(paddr, TSC_CTRL_OFS);
  assign cmdWr = wrAccess && isReg(paddr, TSC_CMD_OFS);

  // One-cycle command strobes; the bus never waits on the sequencer
  logic cmdAbort;
  logic cmdInit;
  logic cmdInitAll;
  logic cmdForce;
  logic cmdFetch;
  logic cmdReset;
  logic cmdPreset;
  assign cmdAbort = cmdWr && pwdata[TSC_CMD_ABORT_BIT];
  assign cmdInit = cmdWr && pwdata[TSC_CMD_INIT_BIT];
  assign cmdInitAll = cmdWr && pwdata[TSC_CMD_INITALL_BIT];
  assign cmdForce = cmdWr && pwdata[TSC_CMD_FORCE_BIT];
  assign cmdFetch = cmdWr && pwdata[TSC_CMD_FETCH_BIT];
  assign cmdReset = cmdWr && pwdata[TSC_CMD_CMDRST_BIT];
  assign cmdPreset = cmdWr && pwdata[TSC_CMD_PRESET_BIT];

  logic anyInit;
  logic initRefused;
  logic forceRefused;
  logic contActive;
  assign anyInit = cmdInit || cmdInitAll;
  assign contActive = contInit_r || allCont_r;
  assign initRefused = anyInit && (state_r != ST_IDLE || contActive);
  assign forceRefused = cmdForce && state_r != ST_WAIT;

  // Trigger qualifier per source
  logic srcTrig;
  always_comb begin
    case (source_r)
      TSC_SRC_BUS: srcTrig = busSync;
      TSC_SRC_EXT: srcTrig = extSync;
      TSC_SRC_IMM: srcTrig = 1'b1;
      TSC_SRC_INT: srcTrig = intSync;
      default: srcTrig = 1'b0;
    endcase
  end

  logic settleDone;
  logic measDone;
  assign settleDone = state_r == ST_SETTLE && count_r == SETTLE_LAST;
  assign measDone = state_r == ST_MEAS && count_r == MEAS_LAST;

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (contActive) begin
          state_nxt = ST_WAIT;
        end else if (anyInit && !initRefused) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cmdAbort) begin
          state_nxt = ST_IDLE;
        end else if (cmdForce) begin
          state_nxt = ST_MEAS;
        end else if (srcTrig) begin
          state_nxt = autoDelay_r ? ST_SETTLE : ST_MEAS;
        end
      end
      ST_SETTLE: begin
        if (cmdAbort) begin
          state_nxt = ST_IDLE;
        end else if (settleDone) begin
          state_nxt = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (cmdAbort) begin
          state_nxt = ST_IDLE;
        end else if (measDone) begin
          state_nxt = contActive ? ST_WAIT : ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (cmdReset || cmdPreset) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      count_r <= 16'h0000;
    end else begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Settings survive abort; only resets and writes change them
  always_ff @(posedge clock) begin
    if (sys_rst || cmdPreset) begin
      contInit_r <= TSC_CONT_PWRUP;
      allCont_r <= TSC_ALLCONT_PWRUP;
      autoDelay_r <= TSC_AUTODLY_PWRUP;
      source_r <= TSC_SRC_IMM;
    end else if (cmdReset) begin
      contInit_r <= 1'b0;
      allCont_r <= 1'b0;
      autoDelay_r <= 1'b1;
      source_r <= TSC_SRC_IMM;
    end else if (ctrlWr) begin
      contInit_r <= pwdata[TSC_CTRL_CONT_BIT];
      allCont_r <= pwdata[TSC_CTRL_ALLCONT_BIT];
      autoDelay_r <= pwdata[TSC_CTRL_AUTODLY_BIT];
      source_r <= tsc_src_t'(pwdata[TSC_CTRL_SRC_LSB +: 3]);
    end
  end

  // Result memory and output buffer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result_r <= '0;
      resultValid_r <= 1'b0;
    end else if (measDone) begin
      result_r <= measData;
      resultValid_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      outBuf <= '0;
      outBufValid <= 1'b0;
    end else if (cmdFetch) begin
      outBuf <= result_r;
      outBufValid <= resultValid_r;
    end
  end

  // Pending flag: set while a sequence runs, cleared on return to idle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pending_r <= 1'b0;
    end else if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
      pending_r <= 1'b1;
    end else if (state_r != ST_IDLE && state_nxt == ST_IDLE) begin
      pending_r <= 1'b0;
    end
  end

  // Error latch: a new error wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      errCode_r <= TSC_ERR_NONE;
    end else if (initRefused) begin
      errCode_r <= TSC_ERR_INIT_IGNORED;
    end else if (forceRefused) begin
      errCode_r <= TSC_ERR_TRIG_IGNORED;
    end else if (wrAccess && isReg(paddr, TSC_ERR_OFS)) begin
      errCode_r <= TSC_ERR_NONE;
    end
  end

  // Read data registered from setup phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (isReg(paddr, TSC_CTRL_OFS)) begin
        prdata <= {25'h0, source_r, 1'b0, autoDelay_r, allCont_r, contInit_r};
      end else if (isReg(paddr, TSC_STAT_OFS)) begin
        prdata <= {27'h0, resultValid_r, pending_r, 1'b0, 2'(state_r)};
      end else if (isReg(paddr, TSC_RESULT_OFS)) begin
        prdata <= 32'(result_r);
      end else if (isReg(paddr, TSC_ERR_OFS)) begin
        prdata <= errCode_r;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  logic unusedRd;
  assign unusedRd = rdAccess;

  assign pendingOp = pending_r;
  assign waitingTrig = state_r == ST_WAIT;
  assign measuring = state_r == ST_SETTLE || state_r == ST_MEAS;

endmodule : tsc_trigger_seq

// ==== hw/tsc_pkg.sv ====
// Package for the trigger sequence controller: register map, codes, timing
package tsc_pkg;

  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] TSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] TSC_CMD_OFS = 8'h04;
  localparam logic [7:0] TSC_STAT_OFS = 8'h08;
  localparam logic [7:0] TSC_RESULT_OFS = 8'h0C;
  localparam logic [7:0] TSC_ERR_OFS = 8'h10;

  // CTRL field positions
  localparam int TSC_CTRL_CONT_BIT = 0;
  localparam int TSC_CTRL_ALLCONT_BIT = 1;
  localparam int TSC_CTRL_AUTODLY_BIT = 2;
  localparam int TSC_CTRL_SRC_LSB = 4;

  // CMD field positions (write one to act)
  localparam int TSC_CMD_ABORT_BIT = 0;
  localparam int TSC_CMD_INIT_BIT = 1;
  localparam int TSC_CMD_INITALL_BIT = 2;
  localparam int TSC_CMD_FORCE_BIT = 3;
  localparam int TSC_CMD_FETCH_BIT = 4;
  localparam int TSC_CMD_CMDRST_BIT = 5;
  localparam int TSC_CMD_PRESET_BIT = 6;

  // Error codes, two's complement in a 32-bit word
  localparam logic [31:0] TSC_ERR_NONE = 32'h0000_0000;
  localparam logic [31:0] TSC_ERR_INIT_IGNORED = 32'hFFFF_FF2B;
  localparam logic [31:0] TSC_ERR_TRIG_IGNORED = 32'hFFFF_FF2D;

  // Trigger sources
  typedef enum logic [2:0] {
    TSC_SRC_BUS = 3'h0,
    TSC_SRC_EXT = 3'h1,
    TSC_SRC_HOLD = 3'h2,
    TSC_SRC_IMM = 3'h3,
    TSC_SRC_INT = 3'h4
  } tsc_src_t;

  // Settling interval and measurement length
  localparam int TSC_CLK_HZ = 20000000;
  localparam int TSC_SETTLE_NS = 1000;
  localparam int TSC_SETTLE_CYC = (TSC_SETTLE_NS * (TSC_CLK_HZ / 1000000) + 999) / 1000;
  localparam int TSC_MEAS_CYC = 4;

  // Values after power-up and preset
  localparam logic TSC_CONT_PWRUP = 1'b1;
  localparam logic TSC_ALLCONT_PWRUP = 1'b0;
  localparam logic TSC_AUTODLY_PWRUP = 1'b1;

endpackage : tsc_pkg

// ==== hw/tsc_sync2.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module tsc_sync2 (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Data
  input wire logic din,
  output logic dout
);
  logic stage1_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage1_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule : tsc_sync2

// ==== bench/tsc_front_model.sv ====
// Far-side front end: trigger lines and measurement data
`timescale 1ns/1ns
module tsc_front_model (
  // Clock
  input wire logic clock,
  // Bench control
  input wire logic fire,
  input wire logic [2:0] srcSel,
  input wire logic [15:0] val,
  // Lines into the controller
  output logic extTrig,
  output logic busTrig,
  output logic intLevelTrig,
  output logic [15:0] measData
);
  // Only the selected line carries the level, so a wrong source decode stays armed
  assign busTrig = fire && srcSel == 3'h0;
  assign extTrig = fire && srcSel == 3'h1;
  assign intLevelTrig = fire && srcSel == 3'h4;
  // Sample held in a register, as a converter output would be
  always_ff @(posedge clock) begin
    measData <= val;
  end
endmodule : tsc_front_model

// ==== bench/tsc_trigger_seq_monitor.sv ====
// Port checker of the trigger sequence controller
`timescale 1ns/1ns
module tsc_trigger_seq_monitor
  import tsc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Trigger and data
  input wire logic extTrig,
  input wire logic busTrig,
  input wire logic intLevelTrig,
  input wire logic [DATA_W-1:0] measData,
  // Status
  input wire logic [DATA_W-1:0] outBuf,
  input wire logic outBufValid,
  input wire logic pendingOp,
  input wire logic waitingTrig,
  input wire logic measuring
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable;
  wire cmdW = acc && pwrite && paddr == TSC_CMD_OFS;
  // Length of the current measuring run; a command inside it may cut it short
  logic [15:0] runLen_r;
  logic cmdSeen_r;
  logic runOk;
  always_ff @(posedge clock) begin
    if (sys_rst || !measuring) begin
      runLen_r <= 16'h0000;
      cmdSeen_r <= 1'b0;
    end else begin
      runLen_r <= runLen_r + 16'h0001;
      cmdSeen_r <= cmdSeen_r || cmdW;
    end
  end
  // Measuring spans the settling interval too when auto delay is on
  assign runOk = runLen_r == 16'(TSC_MEAS_CYC) ||
    runLen_r == 16'(TSC_MEAS_CYC + TSC_SETTLE_CYC);
  sequence sMeas4;
    measuring [*4] ##1 !measuring;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr > TSC_ERR_OFS |-> pslverr)
    else $error("no slave error");
  a_unmapped_zero: assert property (acc && !pwrite && paddr > TSC_ERR_OFS |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_one_state: assert property (!(waitingTrig && measuring)) else $error("two states");
  a_meas_len: assert property ($fell(measuring) && !cmdSeen_r |-> runOk)
    else $error("measure length");
  a_busy_pend: assert property (waitingTrig || measuring |-> pendingOp)
    else $error("pending low while busy");
  a_force_meas: assert property (cmdW && pwdata == 32'h08 && waitingTrig |=> sMeas4)
    else $error("force did not measure");
  a_abort_leave: assert property (cmdW && pwdata == 32'h01 |=> !measuring)
    else $error("abort kept measuring");
  a_buf_hold: assert property (!cmdW |=> $stable(outBuf))
    else $error("output buffer moved");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
endmodule : tsc_trigger_seq_monitor
bind tsc_trigger_seq tsc_trigger_seq_monitor #(.DATA_W(DATA_W)) u_mon (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .extTrig(extTrig), .busTrig(busTrig), .intLevelTrig(intLevelTrig), .measData(measData),
  .outBuf(outBuf), .outBufValid(outBufValid), .pendingOp(pendingOp),
  .waitingTrig(waitingTrig), .measuring(measuring)
);

// ==== bench/tsc_trigger_seq_tb.sv ====
// Self-checking bench of the trigger sequence controller
`timescale 1ns/1ns
module tsc_trigger_seq_tb;
  import tsc_pkg::*;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, extTrig, busTrig, intLevelTrig;
  logic outBufValid, pendingOp, waitingTrig, measuring;
  logic [15:0] measData, outBuf, val = 16'h0;
  logic [2:0] srcSel = 3'h0;
  logic [2:0] srcs [3] = '{TSC_SRC_BUS, TSC_SRC_EXT, TSC_SRC_INT};
  int error_cnt = 0, samples_checked = 0, cyc = 0, np, nm;
  tsc_front_model u_fm (.clock(clock), .fire(fire), .srcSel(srcSel), .val(val),
    .extTrig(extTrig), .busTrig(busTrig), .intLevelTrig(intLevelTrig), .measData(measData));
  tsc_trigger_seq #(.DATA_W(16)) u_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extTrig(extTrig), .busTrig(busTrig),
    .intLevelTrig(intLevelTrig), .measData(measData), .outBuf(outBuf),
    .outBufValid(outBufValid), .pendingOp(pendingOp), .waitingTrig(waitingTrig),
    .measuring(measuring));
  initial forever #25 clock = ~clock;
  function automatic logic [31:0] ctrlW(input bit c, a, d, input logic [2:0] s);
    return (32'(c) << TSC_CTRL_CONT_BIT) | (32'(a) << TSC_CTRL_ALLCONT_BIT) |
      (32'(d) << TSC_CTRL_AUTODLY_BIT) | (32'(s) << TSC_CTRL_SRC_LSB);
  endfunction : ctrlW
  // Measuring covers the settling interval as well as the measurement
  function automatic int expMeas(input bit d);
    return (d ? TSC_SETTLE_CYC : 0) + TSC_MEAS_CYC;
  endfunction : expMeas
  function automatic int expPend(input bit d);
    return 1 + expMeas(d);
  endfunction : expPend
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Request held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic win(output int p, m);
    p = 0;
    m = 0;
    repeat (60) begin
      #1;
      if (pendingOp === 1'b1) p++;
      if (measuring === 1'b1) m++;
      @(posedge clock);
    end
  endtask : win
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(97101));
    repeat (5) @(posedge clock);
    sys_rst <= 0;
    apb(0, TSC_CTRL_OFS, 0);
    chk("ctrl_pwrup", rd, ctrlW(1, 0, 1, TSC_SRC_IMM));
    wr(TSC_CTRL_OFS, ctrlW(0, 1, 0, TSC_SRC_IMM));
    apb(0, TSC_CTRL_OFS, 0);
    chk("ctrl_allcont", rd, ctrlW(0, 1, 0, TSC_SRC_IMM));
    wr(TSC_ERR_OFS, 0);
    wr(TSC_CMD_OFS, 32'h02);
    apb(0, TSC_ERR_OFS, 0);
    chk("err_allcont", rd, TSC_ERR_INIT_IGNORED);
    wr(TSC_CMD_OFS, 32'h20);
    apb(0, TSC_CTRL_OFS, 0);
    chk("ctrl_cmdrst", rd, ctrlW(0, 0, 1, TSC_SRC_IMM));
    repeat (40) @(posedge clock);
    apb(0, TSC_STAT_OFS, 0);
    chk("stat_idle", rd[3:0], 0);
    $display("test reset and settings done");
    for (int i = 0; i < 2; i++) begin
      val <= 16'($urandom);
      wr(TSC_CTRL_OFS, ctrlW(0, 0, i[0], TSC_SRC_IMM));
      wr(TSC_CMD_OFS, 32'h02);
      win(np, nm);
      chk("pend_cycles", np, expPend(i[0]));
      chk("meas_cycles", nm, expMeas(i[0]));
      apb(0, TSC_RESULT_OFS, 0);
      chk("result", rd, 32'(val));
      wr(TSC_CMD_OFS, 32'h10);
      @(posedge clock);
      chk("fetch", outBuf, val);
      chk("fetch_valid", outBufValid, 1);
    end
    $display("test single initiation done");
    wr(TSC_CTRL_OFS, ctrlW(0, 0, 1, TSC_SRC_HOLD));
    wr(TSC_ERR_OFS, 0);
    wr(TSC_CMD_OFS, 32'h08);
    apb(0, TSC_ERR_OFS, 0);
    chk("err_force_idle", rd, TSC_ERR_TRIG_IGNORED);
    wr(TSC_CMD_OFS, 32'h02);
    wr(TSC_CMD_OFS, 32'h04);
    apb(0, TSC_ERR_OFS, 0);
    chk("err_init_busy", rd, TSC_ERR_INIT_IGNORED);
    wr(TSC_CMD_OFS, 32'h01);
    apb(0, TSC_STAT_OFS, 0);
    chk("stat_abort", rd[1:0], 0);
    wr(TSC_CMD_OFS, 32'h02);
    apb(0, TSC_STAT_OFS, 0);
    chk("stat_rearm", rd[1:0], 1);
    wr(TSC_CMD_OFS, 32'h08);
    win(np, nm);
    chk("force_pend", np, TSC_MEAS_CYC);
    chk("force_meas", nm, TSC_MEAS_CYC);
    $display("test hold and errors done");
    wr(TSC_CTRL_OFS, ctrlW(1, 0, 0, TSC_SRC_IMM));
    wr(TSC_ERR_OFS, 0);
    wr(TSC_CMD_OFS, 32'h02);
    apb(0, TSC_ERR_OFS, 0);
    chk("err_cont", rd, TSC_ERR_INIT_IGNORED);
    wr(TSC_CMD_OFS, 32'h01);
    // One idle cycle after the abort, then no idle while chaining
    win(np, nm);
    chk("cont_pend", np, 59);
    wr(TSC_CMD_OFS, 32'h20);
    repeat (10) @(posedge clock);
    $display("test continuous done");
    foreach (srcs[k]) begin
      srcSel <= srcs[k];
      wr(TSC_CTRL_OFS, ctrlW(0, 0, 0, srcs[k]));
      wr(TSC_CMD_OFS, k == 0 ? 32'h04 : 32'h02);
      repeat (8) @(posedge clock);
      #1;
      chk("armed", waitingTrig, 1);
      @(posedge clock);
      fire <= 1;
      win(np, nm);
      fire <= 0;
      chk("src_meas", nm, TSC_MEAS_CYC);
      chk("src_idle", pendingOp, 0);
    end
    $display("test sources done");
    wr(TSC_CTRL_OFS, ctrlW(0, 1, 0, TSC_SRC_EXT));
    wr(TSC_CMD_OFS, 32'h40);
    apb(0, TSC_CTRL_OFS, 0);
    chk("ctrl_preset", rd, ctrlW(1, 0, 1, TSC_SRC_IMM));
    $display("test preset done");
    apb(0, 8'h40, 0);
    chk("unmapped_err", se, 1);
    chk("unmapped_data", rd, 0);
    $display("test unmapped done");
    end_sim();
  end
endmodule : tsc_trigger_seq_tb
